// file: pkg/haptic_cal_pkg.sv
package haptic_cal_pkg;
  localparam int ADDR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BRAKE = 8'h1D;
  localparam logic [7:0] IDX_FULL  = 8'h1F;
  localparam logic [7:0] IDX_ODLIM = 8'h20;
  localparam logic [7:0] IDX_LOSS  = 8'h21;
  localparam logic [7:0] IDX_GAIN  = 8'h22;
  localparam logic [7:0] IDX_LOOP  = 8'h23;
  localparam logic [7:0] RST_BRAKE = 8'h00;
  localparam logic [7:0] RST_FULL  = 8'h3F;
  localparam logic [7:0] RST_ODLIM = 8'h89;
  localparam logic [7:0] RST_LOSS  = 8'h0D;
  localparam logic [7:0] RST_GAIN  = 8'h6D;
  localparam logic [7:0] RST_LOOP  = 8'h36;
  // Loop control field positions
  localparam int GATE_BIT   = 7;
  localparam int RATIO_LSB  = 4;
  localparam int LGAIN_LSB  = 2;
  localparam int SCALE_LSB  = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       done;
    logic [7:0] impedance;
    logic [7:0] gain_basis;
  } cal_result_t;

  typedef struct packed {
    logic              valid;
    logic              first;
    logic signed [7:0] level;
  } wave_sample_t;

  typedef struct packed {
    logic              boost;
    logic signed [7:0] level;
  } drive_req_t;
endpackage : haptic_cal_pkg

// file: design/haptic_drive_calibration_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module haptic_drive_calibration_regs (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [haptic_cal_pkg::ADDR_W-1:0] s_awaddr,
  input  wire logic                          s_awvalid,
  output logic                               s_awready,
  input  wire logic [31:0]                   s_wdata,
  input  wire logic [3:0]                    s_wstrb,
  input  wire logic                          s_wvalid,
  output logic                               s_wready,
  output logic [1:0]                         s_bresp,
  output logic                               s_bvalid,
  input  wire logic                          s_bready,
  input  wire logic [haptic_cal_pkg::ADDR_W-1:0] s_araddr,
  input  wire logic                          s_arvalid,
  output logic                               s_arready,
  output logic [31:0]                        s_rdata,
  output logic [1:0]                         s_rresp,
  output logic                               s_rvalid,
  input  wire logic                          s_rready,
  input  wire logic                          closed_loop,
  input  wire logic [7:0]                    waveform_step_period,
  input  haptic_cal_pkg::wave_sample_t       sample,
  input  haptic_cal_pkg::drive_req_t         drive_req,
  input  haptic_cal_pkg::cal_result_t        cal,
  output logic signed [16:0]                 brake_offset,
  output logic signed [7:0]                  brake_level,
  output logic signed [9:0]                  drive_out,
  output logic [7:0]                         full_scale_level,
  output logic [7:0]                         loss_comp,
  output logic [7:0]                         feedback_gain,
  output logic                               noise_gate_level,
  output logic [2:0]                         brake_gain_ratio,
  output logic [1:0]                         loop_gain_sel,
  output logic [1:0]                         backemf_scale
);
  import haptic_cal_pkg::*;

  logic [7:0]  brake_time_adjust;
  logic [7:0]  full_scale_drive_level;
  logic [7:0]  overdrive_limit_level;
  logic [7:0]  loss_compensation_result;
  logic [7:0]  feedback_gain_basis;
  logic [7:0]  feedback_loop_control;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_idx;
  logic [7:0]  w_byte;
  logic        w_lane;

  logic [7:0]  next_brake;
  logic [7:0]  next_full;
  logic [7:0]  next_odlim;
  logic [7:0]  next_loss;
  logic [7:0]  next_gain;
  logic [7:0]  next_loop;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_idx;
  logic [7:0]  next_w_byte;
  logic        next_w_lane;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic signed [16:0] next_brake_offset;
  logic signed [7:0]  next_brake_level;
  logic signed [9:0]  next_drive_out;

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == IDX_BRAKE) || (idx == IDX_FULL) ||
             (idx == IDX_ODLIM) || (idx == IDX_LOSS) ||
             (idx == IDX_GAIN)  || (idx == IDX_LOOP);
  endfunction : mapped

  // Register file and bus slave
  always_comb begin
    logic       commit;
    logic [7:0] ridx;
    commit       = 1'b0;
    ridx         = s_araddr[ADDR_W-1:2];
    next_brake   = brake_time_adjust;
    next_full    = full_scale_drive_level;
    next_odlim   = overdrive_limit_level;
    next_loss    = loss_compensation_result;
    next_gain    = feedback_gain_basis;
    next_loop    = feedback_loop_control;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = s_bvalid;
    next_bresp   = s_bresp;
    next_rvalid  = s_rvalid;
    next_rdata   = s_rdata;
    next_rresp   = s_rresp;
    if (s_awvalid && s_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_awaddr[ADDR_W-1:2];
    end
    if (s_wvalid && s_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_wdata[7:0];
      next_w_lane = s_wstrb[0];
    end
    if (s_bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_bvalid) begin
      commit       = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (commit && w_lane) begin
      unique case (aw_idx)
        IDX_BRAKE: next_brake = w_byte;
        IDX_FULL:  next_full  = w_byte;
        IDX_ODLIM: next_odlim = w_byte;
        IDX_LOSS:  next_loss  = w_byte;
        IDX_GAIN:  next_gain  = w_byte;
        IDX_LOOP:  next_loop  = w_byte;
        default:   ;
      endcase
    end
    // Calibration beats a host write in the same cycle
    if (cal.done) begin
      next_loss = cal.impedance;
      next_gain = cal.gain_basis;
    end
    if (s_rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      unique case (ridx)
        IDX_BRAKE: next_rdata[7:0] = brake_time_adjust;
        IDX_FULL:  next_rdata[7:0] = full_scale_drive_level;
        IDX_ODLIM: next_rdata[7:0] = overdrive_limit_level;
        IDX_LOSS:  next_rdata[7:0] = loss_compensation_result;
        IDX_GAIN:  next_rdata[7:0] = feedback_gain_basis;
        IDX_LOOP:  next_rdata[7:0] = feedback_loop_control;
        default:   ;
      endcase
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brake_time_adjust        <= RST_BRAKE;
      full_scale_drive_level   <= RST_FULL;
      overdrive_limit_level    <= RST_ODLIM;
      loss_compensation_result <= RST_LOSS;
      feedback_gain_basis      <= RST_GAIN;
      feedback_loop_control    <= RST_LOOP;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_idx    <= 8'h00;
      w_byte    <= 8'h00;
      w_lane    <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else begin
      brake_time_adjust        <= next_brake;
      full_scale_drive_level   <= next_full;
      overdrive_limit_level    <= next_odlim;
      loss_compensation_result <= next_loss;
      feedback_gain_basis      <= next_gain;
      feedback_loop_control    <= next_loop;
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      aw_idx    <= next_aw_idx;
      w_byte    <= next_w_byte;
      w_lane    <= next_w_lane;
      s_awready <= next_awready;
      s_wready  <= next_wready;
      s_bvalid  <= next_bvalid;
      s_bresp   <= next_bresp;
      s_arready <= next_arready;
      s_rvalid  <= next_rvalid;
      s_rdata   <= next_rdata;
      s_rresp   <= next_rresp;
    end
  end

  // Configuration outputs are the register flops themselves
  assign full_scale_level = full_scale_drive_level;
  assign loss_comp        = loss_compensation_result;
  assign feedback_gain    = feedback_gain_basis;
  assign noise_gate_level = feedback_loop_control[GATE_BIT];
  assign brake_gain_ratio = feedback_loop_control[RATIO_LSB +: 3];
  assign loop_gain_sel    = feedback_loop_control[LGAIN_LSB +: 2];
  assign backemf_scale    = feedback_loop_control[SCALE_LSB +: 2];

  // Playback-side datapath
  always_comb begin
    logic signed [9:0] lvl;
    logic signed [9:0] lim;
    lvl = 10'(drive_req.level);
    lim = $signed({2'b00, full_scale_drive_level});
    // Boost periods may run past full scale, up to the limit
    if (closed_loop && drive_req.boost) begin
      lim = $signed({2'b00, overdrive_limit_level});
    end
    if (!closed_loop) begin
      next_drive_out = lvl;
    end else if (lvl > lim) begin
      next_drive_out = lim;
    end else if (lvl < -lim) begin
      next_drive_out = -lim;
    end else begin
      next_drive_out = lvl;
    end
    if (closed_loop) begin
      next_brake_offset = 17'sh00000;
    end else begin
      next_brake_offset = $signed(brake_time_adjust) *
                          $signed({1'b0, waveform_step_period});
    end
    next_brake_level = brake_level;
    if (sample.valid) begin
      if (sample.first || (sample.level < brake_level)) begin
        next_brake_level = sample.level;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brake_offset <= 17'sh00000;
      brake_level  <= 8'sh00;
      drive_out    <= 10'sh000;
    end else begin
      brake_offset <= next_brake_offset;
      brake_level  <= next_brake_level;
      drive_out    <= next_drive_out;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  brake_open_a: assert property (
    !closed_loop |=> brake_offset == $signed($past(brake_time_adjust)) *
      $signed({1'b0, $past(waveform_step_period)}))
    else $error("brake offset not register times step period");

  brake_closed_a: assert property (
    closed_loop |=> brake_offset == 17'sh00000)
    else $error("brake offset nonzero in closed loop");

  brake_min_a: assert property (
    sample.valid && !sample.first |=> brake_level <= $past(brake_level)
      && brake_level <= $past(sample.level))
    else $error("brake level is not the running minimum");

  overdrive_limit_level_a: assert property (
    closed_loop && drive_req.boost |=>
      drive_out <= $signed({2'b00, $past(overdrive_limit_level)}) &&
      drive_out >= -$signed({2'b00, $past(overdrive_limit_level)}))
    else $error("boost drive exceeds overdrive limit");

  fs_clamp_a: assert property (
    closed_loop && !drive_req.boost |=>
      drive_out <= $signed({2'b00, $past(full_scale_drive_level)}) &&
      drive_out >= -$signed({2'b00, $past(full_scale_drive_level)}))
    else $error("closed loop drive exceeds full scale");

  cal_loss_a: assert property (
    cal.done |=> loss_comp == $past(cal.impedance))
    else $error("calibration loss result not stored");

  cal_gain_a: assert property (
    cal.done |=> feedback_gain == $past(cal.gain_basis))
    else $error("calibration gain basis not stored");

  read_back_a: assert property (
    s_arvalid && s_arready && s_araddr[ADDR_W-1:2] == IDX_BRAKE |=>
      s_rvalid && s_rdata == {24'h000000, $past(brake_time_adjust)})
    else $error("read data does not match register");

  resp_hold_a: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped before bready");

  write_cover_c: cover property (s_bvalid && s_bready);
  read_cover_c:  cover property (s_rvalid && s_rready);
  cal_cover_c:   cover property (cal.done);
  boost_cover_c: cover property (closed_loop && drive_req.boost);
endmodule : haptic_drive_calibration_regs

// file: dv/haptic_drive_calibration_regs_bench.sv
`timescale 1ns/100ps
module haptic_drive_calibration_regs_bench;
  import haptic_cal_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic       wr;
    logic [7:0] d;
    logic [7:0] exp;
    logic [1:0] resp;
  } row_t;
  typedef struct packed {
    logic       cl;
    logic       bst;
    logic [7:0] lvl;
    logic [9:0] exp;
  } drv_t;
  logic              aclk, aresetn, s_awvalid, s_wvalid, s_bready;
  logic              s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
  logic              s_arready, s_rvalid, closed_loop, noise_gate_level;
  logic [ADDR_W-1:0] s_awaddr, s_araddr;
  logic [31:0]       s_wdata, s_rdata;
  logic [3:0]        s_wstrb;
  logic [1:0]        s_bresp, s_rresp, loop_gain_sel, backemf_scale, rsp;
  logic [7:0]        waveform_step_period, full_scale_level, loss_comp;
  logic [7:0]        feedback_gain;
  logic [2:0]        brake_gain_ratio;
  logic [31:0]       rd;
  logic signed [16:0] brake_offset;
  logic signed [7:0] brake_level;
  logic signed [9:0] drive_out;
  wave_sample_t      sample;
  drive_req_t        drive_req;
  cal_result_t       cal;
  int                errors, check_count;
  // Reset values first, then each register written and read back
  row_t rows [14] = '{
    '{8'h1D,1'b0,8'h00,8'h00,RESP_OKAY}, '{8'h1F,1'b0,8'h00,8'h3F,RESP_OKAY},
    '{8'h20,1'b0,8'h00,8'h89,RESP_OKAY}, '{8'h21,1'b0,8'h00,8'h0D,RESP_OKAY},
    '{8'h22,1'b0,8'h00,8'h6D,RESP_OKAY}, '{8'h23,1'b0,8'h00,8'h36,RESP_OKAY},
    '{8'h1E,1'b0,8'h00,8'h00,RESP_SLVERR}, '{8'h1D,1'b1,8'hFE,8'hFE,RESP_OKAY},
    '{8'h1F,1'b1,8'h40,8'h40,RESP_OKAY}, '{8'h20,1'b1,8'h50,8'h50,RESP_OKAY},
    '{8'h21,1'b1,8'hA5,8'hA5,RESP_OKAY}, '{8'h22,1'b1,8'h5A,8'h5A,RESP_OKAY},
    '{8'h23,1'b1,8'hC9,8'hC9,RESP_OKAY}, '{8'h1E,1'b1,8'h77,8'h00,RESP_SLVERR}};
  // Full scale 0x40, overdrive limit 0x50 by now
  drv_t drv [6] = '{'{1'b0,1'b0,8'h9C,10'h39C}, '{1'b1,1'b0,8'h64,10'h040},
    '{1'b1,1'b0,8'h9C,10'h3C0}, '{1'b1,1'b1,8'h7F,10'h050},
    '{1'b1,1'b1,8'h80,10'h3B0}, '{1'b1,1'b1,8'h32,10'h032}};

  haptic_drive_calibration_regs u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .closed_loop(closed_loop),
    .waveform_step_period(waveform_step_period), .sample(sample),
    .drive_req(drive_req), .cal(cal), .brake_offset(brake_offset),
    .brake_level(brake_level), .drive_out(drive_out),
    .full_scale_level(full_scale_level), .loss_comp(loss_comp),
    .feedback_gain(feedback_gain), .noise_gate_level(noise_gate_level),
    .brake_gain_ratio(brake_gain_ratio), .loop_gain_sel(loop_gain_sel),
    .backemf_scale(backemf_scale));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task summarize;
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Ready sampled at the falling edge, so the handshake edge is known
  task axi_write(input logic [7:0] idx, input logic [7:0] d,
                 input logic [3:0] st, output logic [1:0] resp);
    logic a, w, ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_awaddr <= {idx, 2'b00};
    s_wdata <= {24'h0, d};
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      a = !ad && s_awready === 1'b1;
      w = !wd && s_wready === 1'b1;
      @(posedge aclk);
      if (a) begin s_awvalid <= 1'b0; ad = 1'b1; end
      if (w) begin s_wvalid <= 1'b0; wd = 1'b1; end
    end
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [7:0] idx, output logic [31:0] d,
                output logic [1:0] resp);
    @(posedge aclk);
    s_araddr <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    resp = s_rresp;
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask : axi_read

  task do_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task play(input logic cl, input logic [7:0] per);
    @(posedge aclk);
    closed_loop <= cl;
    waveform_step_period <= per;
    @(posedge aclk);
    @(negedge aclk);
  endtask : play

  // Valid dropped between samples: one pulse per sample
  task feed(input logic first, input logic [7:0] lvl);
    @(posedge aclk);
    sample <= '{1'b1, first, lvl};
    @(posedge aclk);
    sample <= '0;
  endtask : feed

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {closed_loop, waveform_step_period} = '0;
    sample = '0;
    drive_req = '0;
    cal = '0;
    aresetn = 1'b0;
    errors = 0;
    check_count = 0;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_write(rows[i].idx, rows[i].d, 4'hF, rsp);
        chk("bresp", {30'h0, rows[i].resp}, {30'h0, rsp});
      end
      axi_read(rows[i].idx, rd, rsp);
      chk("rdata", {24'h0, rows[i].exp}, rd);
      chk("rresp", {30'h0, rows[i].resp}, {30'h0, rsp});
    end
    chk("fields", {24'h0, full_scale_level}, 32'h40);
    chk("lp", {23'h0, noise_gate_level, brake_gain_ratio, loop_gain_sel,
        backemf_scale}, 32'hC9);
    foreach (drv[i]) begin
      @(posedge aclk);
      closed_loop <= drv[i].cl;
      drive_req <= '{drv[i].bst, drv[i].lvl};
      @(posedge aclk);
      @(negedge aclk);
      chk("drive_out", 32'($signed(drv[i].exp)), 32'(drive_out));
    end
    play(1'b0, 8'h0A);
    chk("brake_offset", 32'(-20), 32'(brake_offset));
    play(1'b0, 8'hFF);
    chk("brake_offset", 32'(-510), 32'(brake_offset));
    play(1'b1, 8'hFF);
    chk("brake_offset", 32'h0, 32'(brake_offset));
    feed(1'b1, 8'h0A);
    feed(1'b0, 8'hFB);
    feed(1'b0, 8'hD8);
    feed(1'b0, 8'h03);
    @(negedge aclk);
    chk("brake_level", 32'(-40), 32'(brake_level));
    feed(1'b1, 8'h14);
    @(negedge aclk);
    chk("brake_level", 32'h14, 32'(brake_level));
    @(posedge aclk);
    // Loss and gain were written above, so calibration overwrites them
    cal <= '{1'b1, 8'h33, 8'h44};
    @(posedge aclk);
    cal <= '0;
    @(negedge aclk);
    chk("loss_comp", 32'h33, {24'h0, loss_comp});
    chk("feedback_gain", 32'h44, {24'h0, feedback_gain});
    axi_read(IDX_GAIN, rd, rsp);
    chk("rdata", 32'h44, rd);
    // Low strobe: accepted but the register keeps its value
    axi_write(IDX_BRAKE, 8'h11, 4'h0, rsp);
    chk("bresp", 32'h0, {30'h0, rsp});
    axi_read(IDX_BRAKE, rd, rsp);
    chk("rdata", 32'hFE, rd);
    do_reset();
    @(negedge aclk);
    chk("brake_offset", 32'h0, 32'(brake_offset));
    axi_read(IDX_ODLIM, rd, rsp);
    chk("rdata", 32'h89, rd);
    summarize();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    summarize();
  end
endmodule : haptic_drive_calibration_regs_bench
